//--- lvr_pkg.sv
// Purpose: Shared constants and types for the low-voltage reset control block.
// Assumes: Byte-wide register port, one clock, synchronous active-high reset.
// Notes:   Offsets are byte addresses on the plain register port.
package lvr_pkg;
    // Register offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_CAUSE   = 8'h04;
    localparam logic [7:0] OFS_IRQSTAT = 8'h08;
    localparam logic [7:0] OFS_IRQMASK = 8'h0c;
    localparam logic [7:0] OFS_LIVE    = 8'h10;

    // Control register field positions
    localparam int CTL_DETECT_EN  = 0;
    localparam int CTL_STOP_EN    = 1;
    localparam int CTL_RESET_EN   = 2;
    localparam int CTL_THR_SEL    = 3;
    localparam int CTL_WARN_IE    = 4;
    localparam int CTL_WIDTH      = 5;

    // Values after reset
    localparam logic [4:0] CTRL_RST = 5'h05;
    localparam logic [1:0] MASK_RST = 2'h3;
    localparam logic [1:0] STAT_RST = 2'h0;

    // Synchroniser lane positions
    localparam int SY_POR   = 0;
    localparam int SY_LOW   = 1;
    localparam int SY_HIGH  = 2;
    localparam int SY_WARN  = 3;
    localparam int SY_WIDTH = 4;

    // Interrupt status bit positions
    localparam int IS_WARN = 0;
    localparam int IS_TRIP = 1;

    typedef enum logic [1:0] {ST_RUN, ST_POR_HOLD, ST_LVD_HOLD} fsm_t;
endpackage

//--- low_voltage_reset_control.sv
// Purpose: Power-on and low-voltage reset sequencing, cause record, warning interrupt.
// Assumes: Comparator inputs are asynchronous levels, high while the supply is below.
// Notes:   Register port answers reads one cycle later; unmapped reads return zero.
`timescale 1ns/10ps
module low_voltage_reset_control
    import lvr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       powerOnIn,
    input  wire logic       belowLowIn,
    input  wire logic       belowHighIn,
    input  wire logic       supplyWarningIn,
    input  wire logic       stopActive,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    output logic            sysReset,
    output logic            detectOn,
    output logic            deepStopBlock,
    output logic            irq
);

    typedef struct packed {
        logic [SY_WIDTH-1:0]  sync1;
        logic [SY_WIDTH-1:0]  sync2;
        fsm_t                 fsm;
        logic [CTL_WIDTH-1:0] ctrl;
        logic                 causePor;
        logic                 causeLvd;
        logic [1:0]           stat;
        logic [1:0]           mask;
        logic                 sysReset;
        logic                 detOn;
        logic                 deepBlock;
        logic                 irq;
        logic [7:0]           rdata;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    // Address match used by both write and read decode
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    logic porNow;
    logic belowSel;
    logic lvdTrip;
    logic warnCond;

    // Synchronised levels seen by the control logic
    always_comb begin
        porNow   = state_ff.sync2[SY_POR];
        belowSel = state_ff.ctrl[CTL_THR_SEL] ? state_ff.sync2[SY_HIGH]
                                              : state_ff.sync2[SY_LOW];
        lvdTrip  = state_ff.detOn & belowSel;
        warnCond = state_ff.detOn & state_ff.sync2[SY_WARN];
    end

    // Next-state logic for the whole block
    always_comb begin
        nxt_state = state_ff;

        nxt_state.sync1 = {supplyWarningIn, belowHighIn, belowLowIn, powerOnIn};
        nxt_state.sync2 = state_ff.sync1;

        // Software writes
        if (regWr && hit(regAddr, OFS_CTRL)) begin
            nxt_state.ctrl = regWdata[CTL_WIDTH-1:0];
        end
        if (regWr && hit(regAddr, OFS_IRQMASK)) begin
            nxt_state.mask = regWdata[1:0];
        end
        if (regWr && hit(regAddr, OFS_IRQSTAT)) begin
            nxt_state.stat = state_ff.stat & ~regWdata[1:0];
        end

        if (warnCond && state_ff.ctrl[CTL_WARN_IE]) begin
            nxt_state.stat[IS_WARN] = 1'b1;
        end
        // Detection event without reset enabled
        if (state_ff.fsm == ST_RUN && lvdTrip && !state_ff.ctrl[CTL_RESET_EN]) begin
            nxt_state.stat[IS_TRIP] = 1'b1;
        end

        // Reset sequencer
        case (state_ff.fsm)
            ST_RUN: begin
                if (porNow) begin
                    nxt_state.fsm = ST_POR_HOLD;
                end else if (lvdTrip && state_ff.ctrl[CTL_RESET_EN]) begin
                    nxt_state.fsm = ST_LVD_HOLD;
                end
            end
            ST_POR_HOLD: begin
                if (!porNow && !state_ff.sync2[SY_LOW]) begin
                    nxt_state.fsm = ST_RUN;
                end
            end
            ST_LVD_HOLD: begin
                if (porNow) begin
                    nxt_state.fsm = ST_POR_HOLD;
                end else if (!belowSel) begin
                    nxt_state.fsm = ST_RUN;
                end
            end
            default: begin
                nxt_state.fsm = ST_POR_HOLD;
            end
        endcase

        // Power-on reset restores the whole register set
        if (nxt_state.fsm == ST_POR_HOLD) begin
            nxt_state.ctrl = CTRL_RST;
            nxt_state.mask = MASK_RST;
            nxt_state.stat = STAT_RST;
            nxt_state.causePor = 1'b1;
            nxt_state.causeLvd = 1'b1;
        end else if (nxt_state.fsm == ST_LVD_HOLD) begin
            nxt_state.causePor = 1'b0;
            nxt_state.causeLvd = 1'b1;
        end

        // Outputs
        nxt_state.sysReset  = (nxt_state.fsm != ST_RUN);
        nxt_state.detOn     = nxt_state.ctrl[CTL_DETECT_EN]
                              & (!stopActive | nxt_state.ctrl[CTL_STOP_EN]);
        nxt_state.deepBlock = nxt_state.ctrl[CTL_DETECT_EN] & nxt_state.ctrl[CTL_STOP_EN];
        nxt_state.irq       = |(nxt_state.stat & nxt_state.mask);

        // Read data for one cycle after the strobe
        nxt_state.rdata = 8'h00;
        if (regRd) begin
            if (hit(regAddr, OFS_CTRL)) begin
                nxt_state.rdata = {3'h0, state_ff.ctrl};
            end else if (hit(regAddr, OFS_CAUSE)) begin
                nxt_state.rdata = {6'h00, state_ff.causeLvd, state_ff.causePor};
            end else if (hit(regAddr, OFS_IRQSTAT)) begin
                nxt_state.rdata = {6'h00, state_ff.stat};
            end else if (hit(regAddr, OFS_IRQMASK)) begin
                nxt_state.rdata = {6'h00, state_ff.mask};
            end else if (hit(regAddr, OFS_LIVE)) begin
                nxt_state.rdata = {3'h0, state_ff.detOn, state_ff.sync2};
            end
        end

        if (rst) begin
            nxt_state           = '0;
            nxt_state.fsm       = ST_POR_HOLD;
            nxt_state.ctrl      = CTRL_RST;
            nxt_state.mask      = MASK_RST;
            nxt_state.stat      = STAT_RST;
            nxt_state.causePor  = 1'b1;
            nxt_state.causeLvd  = 1'b1;
            nxt_state.sysReset  = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        state_ff <= nxt_state;
    end

    // Output drive straight from the state register
    assign regRdata      = state_ff.rdata;
    assign sysReset      = state_ff.sysReset;
    assign detectOn      = state_ff.detOn;
    assign deepStopBlock = state_ff.deepBlock;
    assign irq           = state_ff.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Reset held in the power-on state; a one-cycle pulse may release at once
    sequence held_s;
        state_ff.sysReset && state_ff.fsm == ST_POR_HOLD;
    endsequence

    // Power-on hold whose release condition is met
    sequence por_clear_s;
        state_ff.fsm == ST_POR_HOLD && !porNow && !state_ff.sync2[SY_LOW];
    endsequence

    // Trip hold whose selected comparator has cleared
    sequence lvd_clear_s;
        state_ff.fsm == ST_LVD_HOLD && !porNow && !belowSel;
    endsequence

    sequence por_seen_s;
        state_ff.sync2[SY_POR] && !$past(rst);
    endsequence

    // Detection follows enable
    detect_gate_a: assert property (state_ff.detOn |-> state_ff.ctrl[CTL_DETECT_EN])
        else $error("detection on without enable");

    // Stop disables detection unless the stop enable bit is set
    stop_off_a: assert property ((stopActive && !nxt_state.ctrl[CTL_STOP_EN])
        |=> !state_ff.detOn)
        else $error("detection left on in stop");

    // Deepest stop refusal
    deep_block_a: assert property (
        (nxt_state.ctrl[CTL_DETECT_EN] && nxt_state.ctrl[CTL_STOP_EN]) |=> state_ff.deepBlock)
        else $error("deepest stop not refused");

    // Power-on forces reset
    por_reset_a: assert property (por_seen_s |=> held_s)
        else $error("power-on without held reset");

    // Power-on hold until low threshold clears
    por_hold_a: assert property (
        (state_ff.fsm == ST_POR_HOLD && state_ff.sync2[SY_LOW]) |=> state_ff.sysReset)
        else $error("power-on reset released early");

    // Power-on cause bits
    por_cause_a: assert property ((state_ff.fsm == ST_POR_HOLD)
        |-> state_ff.causePor && state_ff.causeLvd)
        else $error("power-on cause bits missing");

    // No trip reset without enable
    trip_enable_a: assert property (
        (state_ff.fsm == ST_RUN && !porNow && !state_ff.ctrl[CTL_RESET_EN]) |=> !state_ff.sysReset)
        else $error("reset without reset enable");

    // High threshold chosen by select bit
    thr_select_a: assert property (
        (state_ff.fsm == ST_RUN && !porNow && state_ff.detOn && state_ff.ctrl[CTL_RESET_EN]
         && state_ff.ctrl[CTL_THR_SEL] && state_ff.sync2[SY_HIGH]) |=> state_ff.fsm == ST_LVD_HOLD)
        else $error("high threshold ignored");

    // Trip hold until above threshold
    lvd_hold_a: assert property ((state_ff.fsm == ST_LVD_HOLD && belowSel)
        |=> state_ff.sysReset)
        else $error("trip reset released early");

    // Trip cause bit
    lvd_cause_a: assert property ((state_ff.fsm == ST_LVD_HOLD) |-> state_ff.causeLvd)
        else $error("low-voltage cause missing");

    // Warning flag and request
    warn_flag_a: assert property (
        (warnCond && state_ff.ctrl[CTL_WARN_IE] && state_ff.fsm == ST_RUN && !porNow
         && nxt_state.mask[IS_WARN]) |=> state_ff.stat[IS_WARN] && state_ff.irq)
        else $error("warning flag or request missing");

    // Synchroniser depth
    sync_chain_a: assert property (##2 state_ff.sync2 == $past(state_ff.sync1))
        else $error("synchroniser stage mismatch");

    // Read data only in the cycle after a read strobe
    rdata_idle_a: assert property (!regRd |=> state_ff.rdata == 8'h00)
        else $error("read data without read strobe");

    // Control read returns the control word
    rdata_ctrl_a: assert property (
        (regRd && regAddr == OFS_CTRL) |=> state_ff.rdata == {3'h0, $past(state_ff.ctrl)})
        else $error("control read mismatch");

    // Interrupt level follows unmasked status
    irq_level_a: assert property (
        (|(state_ff.stat & state_ff.mask)) |-> state_ff.irq)
        else $error("interrupt low with unmasked status");

    // Write-one-clear of the trip status bit
    w1c_clear_a: assert property (
        (regWr && regAddr == OFS_IRQSTAT && regWdata[IS_TRIP]
         && !(state_ff.fsm == ST_RUN && lvdTrip && !state_ff.ctrl[CTL_RESET_EN]))
        |=> !state_ff.stat[IS_TRIP])
        else $error("trip status not cleared");

    // Trip without reset enable records an event
    trip_event_a: assert property (
        (state_ff.fsm == ST_RUN && !porNow && lvdTrip && !state_ff.ctrl[CTL_RESET_EN])
        |=> state_ff.stat[IS_TRIP])
        else $error("trip event not recorded");

    // Enabled trip resets and records its cause
    trip_cause_a: assert property (
        (state_ff.fsm == ST_RUN && !porNow && lvdTrip && state_ff.ctrl[CTL_RESET_EN])
        |=> state_ff.causeLvd && !state_ff.causePor && state_ff.sysReset)
        else $error("trip reset or cause missing");

    // Power-on overrides a trip hold
    por_priority_a: assert property (
        (state_ff.fsm == ST_LVD_HOLD && porNow) |=> state_ff.fsm == ST_POR_HOLD)
        else $error("power-on ignored during trip hold");

    // Every hold state drives reset
    hold_reset_a: assert property ((state_ff.fsm != ST_RUN) |-> state_ff.sysReset)
        else $error("hold state without reset");

    // Deepest stop allowed without detection
    deep_off_a: assert property (
        !nxt_state.ctrl[CTL_DETECT_EN] |=> !state_ff.deepBlock)
        else $error("deepest stop refused without detection");

    // Power-on restores control defaults
    por_defaults_a: assert property (
        porNow |=> state_ff.ctrl == CTRL_RST && state_ff.mask == MASK_RST)
        else $error("defaults not restored on power-on");

    // No trip while detection is off
    no_detect_a: assert property (
        (state_ff.fsm == ST_RUN && !porNow && !state_ff.detOn) |=> state_ff.fsm == ST_RUN)
        else $error("trip while detection off");

    // Warning flag stays clear without interrupt enable
    warn_gate_a: assert property (
        (!state_ff.ctrl[CTL_WARN_IE] && !state_ff.stat[IS_WARN]) |=> !state_ff.stat[IS_WARN])
        else $error("warning flag set without enable");

    // Power-on hold releases once clear
    por_release_a: assert property (por_clear_s |=> !state_ff.sysReset)
        else $error("power-on hold not released");

    // Trip hold releases once clear
    lvd_release_a: assert property (lvd_clear_s |=> !state_ff.sysReset)
        else $error("trip hold not released");

endmodule

//--- supply_comparator_model.sv
// Purpose: Behavioural supply comparators facing the reset control block.
// Assumes: supplyLvl 0 below rearm, 1 below low, 2 below high, 3 below warn, 4 fine.
// Notes:   Thresholds nest, so a low supply trips every comparator above it.
`timescale 1ns/10ps
module supply_comparator_model #(
    parameter int SETTLE = 3
) (
    input  wire logic [2:0] supplyLvl,
    output logic            powerOnIn,
    output logic            belowLowIn,
    output logic            belowHighIn,
    output logic            supplyWarningIn
);
    // Nested comparisons with analog settling delay
    assign #(SETTLE) powerOnIn       = (supplyLvl == 3'h0);
    assign #(SETTLE) belowLowIn      = (supplyLvl <= 3'h1);
    assign #(SETTLE) belowHighIn     = (supplyLvl <= 3'h2);
    assign #(SETTLE) supplyWarningIn = (supplyLvl <= 3'h3);
endmodule

//--- testbench.sv
// Purpose: Self-checking bench for the low-voltage reset control block.
// Assumes: Register reads answer one cycle after the strobe.
// Notes:   Random control words and stop levels mixed with fixed corners.
`timescale 1ns/10ps
module testbench;
    import lvr_pkg::*;
    logic       clk;
    logic       rst;
    logic [2:0] lvl;
    logic       stopActive;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic       regWr;
    logic       regRd;
    logic [7:0] regRdata;
    logic       sysReset;
    logic       detectOn;
    logic       deepStopBlock;
    logic       irq;
    logic       por;
    logic       bLow;
    logic       bHigh;
    logic       warn;
    int         bad_count;
    int         n_checks;
    int         seed;
    logic [4:0] c;
    logic       s;

    supply_comparator_model i_cmp (.supplyLvl(lvl), .powerOnIn(por), .belowLowIn(bLow),
        .belowHighIn(bHigh), .supplyWarningIn(warn));
    low_voltage_reset_control i_dut (.clk(clk), .rst(rst), .powerOnIn(por),
        .belowLowIn(bLow), .belowHighIn(bHigh), .supplyWarningIn(warn),
        .stopActive(stopActive), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .sysReset(sysReset), .detectOn(detectOn),
        .deepStopBlock(deepStopBlock), .irq(irq));

    // Clock generator
    always #10 clk = ~clk;

    // Expected comparator enable
    function automatic logic expDet(input logic [4:0] w, input logic st);
        return w[CTL_DETECT_EN] & (~st | w[CTL_STOP_EN]);
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] e, input string m);
        n_checks++;
        if (got !== e) begin
            bad_count++;
            $display("BAD %0t %s got %h want %h", $time, m, got, e);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, e, "read data");
    endtask

    // Bounded wait for the reset output
    task automatic waitRst(input logic e);
        for (int i = 0; i < 20 && sysReset !== e; i++) tick(1);
        chk({7'h0, sysReset}, {7'h0, e}, "reset level");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        {clk, regWr, regRd, stopActive} = 4'h0;
        {regAddr, regWdata} = 16'h0;
        rst = 1'b1;
        lvl = 3'h0;
        seed = 32'ha285e337;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tick(8);
        chk({7'h0, sysReset}, 8'h01, "held at power on");
        lvl <= 3'h1;
        tick(8);
        chk({7'h0, sysReset}, 8'h01, "held below low");
        lvl <= 3'h4;
        waitRst(1'b0);
        rd(OFS_CAUSE, 8'h03);
        rd(OFS_CTRL, 8'h05);
        rd(OFS_IRQMASK, 8'h03);
        rd(OFS_LIVE, 8'h10);
        // Trip on the high threshold with reset enabled
        wr(OFS_CTRL, 8'h0d);
        lvl <= 3'h2;
        waitRst(1'b1);
        tick(8);
        chk({7'h0, sysReset}, 8'h01, "trip hold");
        lvl <= 3'h4;
        waitRst(1'b0);
        rd(OFS_CAUSE, 8'h02);
        // Low threshold selected ignores the high comparator
        wr(OFS_CTRL, 8'h05);
        lvl <= 3'h2;
        tick(8);
        chk({7'h0, sysReset}, 8'h00, "low threshold only");
        // Reset enable clear: event only
        wr(OFS_CTRL, 8'h01);
        lvl <= 3'h1;
        tick(8);
        chk({7'h0, sysReset}, 8'h00, "no reset");
        rd(OFS_IRQSTAT, 8'h02);
        chk({7'h0, irq}, 8'h01, "trip irq");
        lvl <= 3'h4;
        tick(4);
        wr(OFS_IRQSTAT, 8'h02);
        tick(2);
        chk({7'h0, irq}, 8'h00, "cleared irq");
        // Warning with and without interrupt enable
        wr(OFS_CTRL, 8'h15);
        lvl <= 3'h3;
        tick(6);
        chk({7'h0, irq}, 8'h01, "warn irq");
        rd(OFS_IRQSTAT, 8'h01);
        wr(OFS_IRQMASK, 8'h00);
        tick(2);
        chk({7'h0, irq}, 8'h00, "masked irq");
        lvl <= 3'h4;
        tick(4);
        wr(OFS_IRQSTAT, 8'h01);
        wr(OFS_IRQMASK, 8'h03);
        wr(OFS_CTRL, 8'h05);
        lvl <= 3'h3;
        tick(6);
        rd(OFS_IRQSTAT, 8'h00);
        lvl <= 3'h4;
        // Detection disabled ignores low supply
        wr(OFS_CTRL, 8'h04);
        tick(2);
        chk({7'h0, detectOn}, 8'h00, "detect off");
        lvl <= 3'h1;
        tick(8);
        chk({7'h0, sysReset}, 8'h00, "no detect no reset");
        lvl <= 3'h4;
        tick(4);
        // Stop behaviour: corners first, then random control words
        for (int i = 0; i < 12; i++) begin
            c = (i == 0) ? 5'h03 : (i == 1) ? 5'h01 : 5'($random(seed));
            s = (i < 2) ? 1'b1 : 1'($random(seed));
            wr(OFS_CTRL, {3'h0, c});
            stopActive <= s;
            tick(3);
            chk({7'h0, detectOn}, {7'h0, expDet(c, s)}, "stop detect");
            chk({7'h0, deepStopBlock}, {7'h0, c[0] & c[1]}, "deep stop");
            rd(OFS_LIVE, {3'h0, expDet(c, s), 4'h0});
        end
        stopActive <= 1'b0;
        // Power-on in mid-run, then read-only and unmapped places
        lvl <= 3'h0;
        waitRst(1'b1);
        lvl <= 3'h4;
        waitRst(1'b0);
        rd(OFS_CAUSE, 8'h03);
        wr(OFS_CAUSE, 8'h00);
        rd(OFS_CAUSE, 8'h03);
        rd(8'h14, 8'h00);
        tally_and_finish();
    end
endmodule
